//--- core/crg_pkg.sv
// Shared constants and types for the clock, reference and misc control block.
// Assumes a single 40 MHz system clock, ref_clk, drives all logic.
package crg_pkg;

  localparam int CRG_CLK_HZ = 40000000;
  localparam int CRG_CLK_PERIOD_NS = 25;

  // Line rates in hertz and strap base rates in kHz.
  localparam longint CRG_T1_HZ = 1544000;
  localparam longint CRG_E1_HZ = 2048000;
  localparam logic [13:0] CRG_T1_KHZ = 14'h0608;
  localparam logic [13:0] CRG_E1_KHZ = 14'h0800;

  // Phase increments for a 32-bit accumulator clocked at CRG_CLK_HZ.
  localparam int CRG_PHASE_W = 32;
  localparam logic [31:0] CRG_INC_T1 = 32'((CRG_T1_HZ << 32) / longint'(CRG_CLK_HZ));
  localparam logic [31:0] CRG_INC_E1 = 32'((CRG_E1_HZ << 32) / longint'(CRG_CLK_HZ));

  // Reset and access timing.
  localparam int CRG_RST_MIN_NS = 100;
  localparam int CRG_RST_MIN_CYC = (CRG_RST_MIN_NS + CRG_CLK_PERIOD_NS - 1) / CRG_CLK_PERIOD_NS;
  localparam int CRG_ACCESS_DELAY_MS = 2;
  localparam int CRG_ACCESS_DELAY_CYC = CRG_ACCESS_DELAY_MS * (CRG_CLK_HZ / 1000);

  // Oscillator activity window in cycles.
  localparam int CRG_OSC_TIMEOUT_CYC = 255;

  // Register map.
  localparam logic [7:0] CRG_GP_CTRL_ADDR = 8'h06;
  localparam logic [7:0] CRG_REF_CTRL_ADDR = 8'h3e;
  localparam int CRG_GP_DIR_BIT = 0;
  localparam int CRG_GP_VAL_BIT = 2;
  localparam int CRG_REF_HOLD_BIT = 0;
  localparam logic [7:0] CRG_GP_CTRL_RESET = 8'h00;
  localparam logic [7:0] CRG_REF_CTRL_RESET = 8'h00;

  // Strap fields.
  localparam int CRG_STRAP_RATE_BIT = 2;

  typedef struct packed {
    logic rate_e1;
    logic [2:0] mult;
  } crg_strap_t;

  typedef enum logic [1:0] {
    CRG_ST_WAIT = 2'b01,
    CRG_ST_RUN = 2'b10
  } crg_state_t;

endpackage : crg_pkg

//--- core/crg_nco.sv
// Numerically controlled oscillator standing in for the master clock PLL.
// Assumes it runs on ref_clk and that enable drops when the oscillator stops.
`timescale 1ns/1ps
`default_nettype none
module crg_nco
  import crg_pkg::*;
#(
  parameter int PHASE_W = CRG_PHASE_W
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic enable,
  input wire logic [PHASE_W-1:0] increment,
  output logic clk_out
);

  logic [PHASE_W-1:0] phase_q;
  logic [PHASE_W-1:0] phase_d;
  logic clk_q;
  logic clk_d;

  // The output is the registered accumulator msb, so its edges jitter by one ref_clk period.
  always_comb begin
    phase_d = phase_q;
    if (enable) begin
      phase_d = phase_q + increment;
    end
    clk_d = phase_d[PHASE_W-1];
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      phase_q <= '0;
      clk_q <= 1'b0;
    end else begin
      phase_q <= phase_d;
      clk_q <= clk_d;
    end
  end

  assign clk_out = clk_q;

endmodule // crg_nco
`default_nettype wire

//--- core/crg_clock_ctrl.sv
// Clock generation, reference output, reset access delay, GP pin and transmit high-Z.
// Assumes all pin inputs are synchronous to ref_clk and registers use a simple strobe port.
//
// Contract
// - Strap bit 2 low means reference is N x 1.544 MHz, high means N x 2.048.
// - Strap bits 1:0 decode 00,01,10,11 into multiplier N of 1,2,3,4.
// - Generated clock output carries the 1.544 or 2.048 MHz generated line clock.
// - Without signal loss the reference output carries the recovered line clock.
// - On signal loss reference output carries master clock or high, per bit 0.
// - Master clock comes from the oscillator input through the internal clock generator.
// - Oscillator output pin is the inverted buffered oscillator input.
// - Reset low longer than 100 ns resets the whole device.
// - Registers become accessible 2 ms after reset; host waits that long.
// - GP control bit 0 makes the general-purpose pin an input or output.
// - GP bit 2 shows the input level, or drives the pin as output.
// - Transmit high-Z input high releases both line transmit pins.
`timescale 1ns/1ps
`default_nettype none
module crg_clock_ctrl
  import crg_pkg::*;
#(
  parameter int ACCESS_DELAY_CYC = CRG_ACCESS_DELAY_CYC,
  parameter int OSC_TIMEOUT_CYC = CRG_OSC_TIMEOUT_CYC
) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic oscillator_input,
  output logic oscillator_output,
  input wire logic [2:0] clock_select_strap,
  output crg_strap_t strap_cfg,
  output logic [13:0] ref_freq_khz,
  output logic osc_active,
  output logic generated_line_clock_out,
  input wire logic recovered_line_clock,
  input wire logic signal_absent,
  output logic reference_clock_output,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata,
  output logic reg_rvalid,
  output logic reg_ready,
  input wire logic gp_pin_in,
  output logic gp_pin_out,
  output logic gp_pin_oe,
  input wire logic tx_high_impedance_in,
  input wire logic tx_pos_data,
  input wire logic tx_neg_data,
  output logic line_tx_positive_out,
  output logic line_tx_positive_oe,
  output logic line_tx_negative_out,
  output logic line_tx_negative_oe
);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Access delay after reset.

  localparam int DLY_W = $clog2(ACCESS_DELAY_CYC + 1);

  crg_state_t state_q;
  crg_state_t state_d;
  logic [DLY_W-1:0] dly_q;
  logic [DLY_W-1:0] dly_d;
  logic strap_take_q;
  logic strap_take_d;

  always_comb begin
    state_d = state_q;
    dly_d = dly_q;
    strap_take_d = 1'b0;
    case (state_q)
      CRG_ST_WAIT: begin
        if (dly_q == DLY_W'(ACCESS_DELAY_CYC - 1)) begin
          state_d = CRG_ST_RUN;
        end else begin
          dly_d = dly_q + DLY_W'(1);
        end
        strap_take_d = (dly_q == '0);
      end
      CRG_ST_RUN: begin
        state_d = CRG_ST_RUN;
      end
      default: begin
        state_d = CRG_ST_WAIT;
        dly_d = '0;
      end
    endcase
  end

  // The reset is taken asynchronously; a glitch shorter than the minimum pulse may still act.
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      state_q <= CRG_ST_WAIT;
      dly_q <= '0;
      strap_take_q <= 1'b0;
    end else begin
      state_q <= state_d;
      dly_q <= dly_d;
      strap_take_q <= strap_take_d;
    end
  end

  assign reg_ready = (state_q == CRG_ST_RUN);

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Strap capture and decode.

  crg_strap_t strap_q;
  crg_strap_t strap_d;
  logic [13:0] freq_q;
  logic [13:0] freq_d;

  always_comb begin
    strap_d = strap_q;
    if (strap_take_q) begin
      strap_d.rate_e1 = clock_select_strap[CRG_STRAP_RATE_BIT];
      strap_d.mult = {1'b0, clock_select_strap[1:0]} + 3'h1;
    end
    freq_d = 14'(strap_q.mult) * (strap_q.rate_e1 ? CRG_E1_KHZ : CRG_T1_KHZ);
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      strap_q <= '{rate_e1: 1'b0, mult: 3'h1};
      freq_q <= CRG_T1_KHZ;
    end else begin
      strap_q <= strap_d;
      freq_q <= freq_d;
    end
  end

  assign strap_cfg = strap_q;
  assign ref_freq_khz = freq_q;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Oscillator buffer, activity watch and master clock.

  localparam int OSC_W = $clog2(OSC_TIMEOUT_CYC + 1);

  logic osc_prev_q;
  logic [OSC_W-1:0] osc_cnt_q;
  logic [OSC_W-1:0] osc_cnt_d;
  logic master_clk;

  assign oscillator_output = ~oscillator_input;

  always_comb begin
    osc_cnt_d = osc_cnt_q;
    if (oscillator_input != osc_prev_q) begin
      osc_cnt_d = OSC_W'(OSC_TIMEOUT_CYC);
    end else if (osc_cnt_q != '0) begin
      osc_cnt_d = osc_cnt_q - OSC_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      osc_prev_q <= 1'b0;
      osc_cnt_q <= '0;
    end else begin
      osc_prev_q <= oscillator_input;
      osc_cnt_q <= osc_cnt_d;
    end
  end

  assign osc_active = (osc_cnt_q != '0);

  // The generator free-runs only while the oscillator toggles, so a dead crystal stops it.
  crg_nco u_nco (
    .ref_clk(ref_clk),
    .resetn(resetn),
    .enable(osc_active),
    .increment(strap_q.rate_e1 ? CRG_INC_E1 : CRG_INC_T1),
    .clk_out(master_clk)
  );

  assign generated_line_clock_out = master_clk;

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Registers and register port.

  logic [7:0] gp_ctrl_q;
  logic [7:0] gp_ctrl_d;
  logic [7:0] ref_ctrl_q;
  logic [7:0] ref_ctrl_d;
  logic [7:0] rdata_q;
  logic [7:0] rdata_d;
  logic rvalid_q;
  logic rvalid_d;
  logic [7:0] gp_view;

  always_comb begin
    gp_ctrl_d = gp_ctrl_q;
    ref_ctrl_d = ref_ctrl_q;
    rdata_d = rdata_q;
    rvalid_d = 1'b0;
    gp_view = 8'h00;
    gp_view[CRG_GP_DIR_BIT] = gp_ctrl_q[CRG_GP_DIR_BIT];
    gp_view[CRG_GP_VAL_BIT] = gp_ctrl_q[CRG_GP_DIR_BIT] ? gp_ctrl_q[CRG_GP_VAL_BIT]
                                                        : gp_pin_in;
    if (reg_ready && reg_wr) begin
      if (reg_addr == CRG_GP_CTRL_ADDR) begin
        gp_ctrl_d[CRG_GP_DIR_BIT] = reg_wdata[CRG_GP_DIR_BIT];
        gp_ctrl_d[CRG_GP_VAL_BIT] = reg_wdata[CRG_GP_VAL_BIT];
      end
      if (reg_addr == CRG_REF_CTRL_ADDR) begin
        ref_ctrl_d[CRG_REF_HOLD_BIT] = reg_wdata[CRG_REF_HOLD_BIT];
      end
    end
    if (reg_rd) begin
      rvalid_d = 1'b1;
      rdata_d = 8'h00;
      if (reg_ready) begin
        if (reg_addr == CRG_GP_CTRL_ADDR) begin
          rdata_d = gp_view;
        end else if (reg_addr == CRG_REF_CTRL_ADDR) begin
          rdata_d = ref_ctrl_q;
        end
      end
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      gp_ctrl_q <= CRG_GP_CTRL_RESET;
      ref_ctrl_q <= CRG_REF_CTRL_RESET;
      rdata_q <= 8'h00;
      rvalid_q <= 1'b0;
    end else begin
      gp_ctrl_q <= gp_ctrl_d;
      ref_ctrl_q <= ref_ctrl_d;
      rdata_q <= rdata_d;
      rvalid_q <= rvalid_d;
    end
  end

  assign reg_rdata = rdata_q;
  assign reg_rvalid = rvalid_q;
  assign gp_pin_oe = gp_ctrl_q[CRG_GP_DIR_BIT];
  assign gp_pin_out = gp_ctrl_q[CRG_GP_VAL_BIT];

  //////////////////////////////////////////////////////////////////////////////////////////////
  // Reference output and transmit pins.

  logic refo_q;
  logic refo_d;
  logic txp_q;
  logic txn_q;
  logic txoe_q;

  always_comb begin
    if (!signal_absent) begin
      refo_d = recovered_line_clock;
    end else if (ref_ctrl_q[CRG_REF_HOLD_BIT]) begin
      refo_d = 1'b1;
    end else begin
      refo_d = master_clk;
    end
  end

  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      refo_q <= 1'b0;
      txp_q <= 1'b0;
      txn_q <= 1'b0;
      txoe_q <= 1'b0;
    end else begin
      refo_q <= refo_d;
      txp_q <= tx_pos_data;
      txn_q <= tx_neg_data;
      txoe_q <= ~tx_high_impedance_in;
    end
  end

  assign reference_clock_output = refo_q;
  assign line_tx_positive_out = txp_q;
  assign line_tx_negative_out = txn_q;
  assign line_tx_positive_oe = txoe_q;
  assign line_tx_negative_oe = txoe_q;

endmodule // crg_clock_ctrl
`default_nettype wire

//--- verification/crg_partner.sv
// Far side: oscillator source, recovered line clock and the GP pin wire.
// Assumes the bench clock; the GP pin has a pull-up.
`timescale 1ns/1ps
`default_nettype none
module crg_partner (
  input wire logic ref_clk,
  input wire logic osc_run,
  input wire logic gp_pin_out,
  input wire logic gp_pin_oe,
  input wire logic ext_en,
  input wire logic ext_lvl,
  output logic oscillator_input,
  output logic recovered_line_clock,
  output logic gp_pin_in
);
  logic [1:0] rc_q = 2'h0;
  initial begin
    oscillator_input = 1'b0;
    recovered_line_clock = 1'b0;
  end
  // The oscillator never stops across a reset, so resets meet a running clock.
  always @(posedge ref_clk) begin
    #2;
    if (osc_run) oscillator_input = !oscillator_input;
    rc_q = (rc_q == 2'h2) ? 2'h0 : rc_q + 2'h1;
    if (rc_q == 2'h0) recovered_line_clock = !recovered_line_clock;
  end
  // Released pin floats to the pull-up level unless ext_en drives ext_lvl onto it.
  assign gp_pin_in = gp_pin_oe ? gp_pin_out : (ext_en ? ext_lvl : 1'b1);
endmodule // crg_partner
`default_nettype wire

//--- verification/crg_clock_ctrl_asserts.sv
// Port checker for the clock control block.
// Assumes it is bound into crg_clock_ctrl.
`timescale 1ns/1ps
`default_nettype none
module crg_clock_ctrl_asserts
  import crg_pkg::*;
#(parameter int ACCESS_DELAY_CYC = 20) (
  input wire logic ref_clk,
  input wire logic resetn,
  input wire logic oscillator_input,
  input wire logic oscillator_output,
  input wire crg_strap_t strap_cfg,
  input wire logic [13:0] ref_freq_khz,
  input wire logic generated_line_clock_out,
  input wire logic recovered_line_clock,
  input wire logic signal_absent,
  input wire logic reference_clock_output,
  input wire logic [7:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  input wire logic [7:0] reg_rdata,
  input wire logic reg_rvalid,
  input wire logic reg_ready,
  input wire logic gp_pin_in,
  input wire logic gp_pin_oe,
  input wire logic gp_pin_out,
  input wire logic tx_high_impedance_in,
  input wire logic line_tx_positive_oe,
  input wire logic line_tx_negative_oe
);
  logic hold_q, hold_d;
  int cnt_q, cnt_d;
  always_comb begin
    hold_d = hold_q;
    if (reg_wr && reg_ready && reg_addr == CRG_REF_CTRL_ADDR) hold_d = reg_wdata[0];
    cnt_d = (cnt_q < 1000) ? cnt_q + 1 : cnt_q;
  end
  always_ff @(posedge ref_clk or negedge resetn) begin
    if (!resetn) begin
      hold_q <= 1'b0;
      cnt_q <= 0;
    end else begin
      hold_q <= hold_d;
      cnt_q <= cnt_d;
    end
  end
  ////////////////////////////////////////
  default clocking cb @(posedge ref_clk); endclocking
  default disable iff (!resetn);
  AST_OSC_INV: assert property (oscillator_output == !oscillator_input)
    else $error("oscillator output not inverted");
  AST_FREQ: assert property (reg_ready |-> ref_freq_khz ==
    14'(strap_cfg.mult) * (strap_cfg.rate_e1 ? 14'h0800 : 14'h0608))
    else $error("reference frequency mismatch");
  AST_STRAP_HOLD: assert property (reg_ready |-> $stable(strap_cfg))
    else $error("strap changed after capture");
  AST_DELAY: assert property ($rose(reg_ready) |-> cnt_q >= ACCESS_DELAY_CYC)
    else $error("access opened early");
  AST_PRE_READY: assert property (reg_rd && !reg_ready |=> reg_rvalid && reg_rdata == 8'h00)
    else $error("early read not zero");
  AST_RD_GP: assert property (reg_rd && reg_ready && !reg_wr && !gp_pin_oe &&
    reg_addr == CRG_GP_CTRL_ADDR |=> reg_rdata[2] == $past(gp_pin_in))
    else $error("gp input level not read");
  AST_GP_WR: assert property (reg_wr && reg_ready && reg_addr == CRG_GP_CTRL_ADDR
    |=> gp_pin_oe == $past(reg_wdata[0]) && gp_pin_out == $past(reg_wdata[2]))
    else $error("gp pin not following write");
  AST_REF_LINE: assert property (!signal_absent && reg_ready
    |=> reference_clock_output == $past(recovered_line_clock))
    else $error("reference not recovered clock");
  AST_REF_LOS: assert property (signal_absent && reg_ready |=> reference_clock_output ==
    ($past(hold_q) ? 1'b1 : $past(generated_line_clock_out)))
    else $error("reference wrong on signal loss");
  AST_TX_HIZ: assert property (tx_high_impedance_in
    |=> !line_tx_positive_oe && !line_tx_negative_oe)
    else $error("transmit pins still driven");
  COV_LOS_HOLD: cover property (signal_absent && hold_q && reg_ready);
  COV_GP_OUT: cover property (gp_pin_oe && gp_pin_out);
  COV_HIZ: cover property (tx_high_impedance_in && reg_ready);
endmodule // crg_clock_ctrl_asserts
bind crg_clock_ctrl crg_clock_ctrl_asserts #(.ACCESS_DELAY_CYC(ACCESS_DELAY_CYC)) u_chk (
  .ref_clk, .resetn, .oscillator_input, .oscillator_output, .strap_cfg, .ref_freq_khz,
  .generated_line_clock_out, .recovered_line_clock, .signal_absent, .reference_clock_output,
  .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid, .reg_ready, .gp_pin_in,
  .gp_pin_oe, .gp_pin_out, .tx_high_impedance_in, .line_tx_positive_oe, .line_tx_negative_oe);
`default_nettype wire

//--- verification/crg_clock_ctrl_test.sv
// Testbench for crg_clock_ctrl with a shortened access delay.
// Assumes the partner model supplies oscillator, line clock and GP wire.
`timescale 1ns/1ps
`default_nettype none
module crg_clock_ctrl_test
  import crg_pkg::*;
;
  localparam int DLY = 20;
  logic ref_clk = 1'b0, resetn = 1'b0, osc_run = 1'b1, ext_en = 1'b0, ext_lvl = 1'b0;
  logic [2:0] clock_select_strap = 3'h0;
  logic signal_absent = 1'b0, reg_wr = 1'b0, reg_rd = 1'b0, tx_high_impedance_in = 1'b0;
  logic tx_pos_data = 1'b0, tx_neg_data = 1'b0;
  logic [7:0] reg_addr = 8'h00, reg_wdata = 8'h00, reg_rdata;
  logic oscillator_input, oscillator_output, generated_line_clock_out, recovered_line_clock;
  logic reference_clock_output, reg_rvalid, reg_ready, gp_pin_in, gp_pin_out, gp_pin_oe;
  logic line_tx_positive_out, line_tx_positive_oe, line_tx_negative_out, line_tx_negative_oe;
  logic [13:0] ref_freq_khz;
  logic osc_active;
  crg_strap_t strap_cfg;
  int cyc = 0, fail_count = 0, num_checks = 0, n1, n2;
  always #12.5 ref_clk = !ref_clk;
  crg_clock_ctrl #(.ACCESS_DELAY_CYC(DLY), .OSC_TIMEOUT_CYC(8)) DUT (.ref_clk, .resetn,
    .oscillator_input, .oscillator_output, .clock_select_strap, .strap_cfg, .ref_freq_khz,
    .osc_active, .generated_line_clock_out, .recovered_line_clock, .signal_absent,
    .reference_clock_output, .reg_addr, .reg_wdata, .reg_wr, .reg_rd, .reg_rdata, .reg_rvalid,
    .reg_ready, .gp_pin_in, .gp_pin_out, .gp_pin_oe, .tx_high_impedance_in, .tx_pos_data,
    .tx_neg_data, .line_tx_positive_out, .line_tx_positive_oe, .line_tx_negative_out,
    .line_tx_negative_oe);
  crg_partner u_far (.ref_clk, .osc_run, .gp_pin_out, .gp_pin_oe, .ext_en, .ext_lvl,
    .oscillator_input, .recovered_line_clock, .gp_pin_in);
  ////////////////////////////////////////
  task automatic report_and_stop;
    $display("checks %0d mismatches %0d", num_checks, fail_count);
    if (fail_count == 0 && num_checks > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask
  task automatic chk(input string what, input logic [13:0] e, input logic [13:0] g);
    num_checks++;
    if (g !== e) begin
      fail_count++;
      $display("MISMATCH %s expected %h seen %h", what, e, g);
    end
  endtask
  task automatic wr_reg(input logic [7:0] a, input logic [7:0] d);
    @(posedge ref_clk);
    #2;
    reg_addr = a;
    reg_wdata = d;
    reg_wr = 1'b1;
    @(posedge ref_clk);
    #2;
    reg_wr = 1'b0;
  endtask
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    @(posedge ref_clk);
    #2;
    reg_addr = a;
    reg_rd = 1'b1;
    @(posedge ref_clk);
    #2;
    reg_rd = 1'b0;
    chk("rvalid", 14'h1, {13'h0, reg_rvalid});
    chk("rdata", {6'h0, e}, {6'h0, reg_rdata});
  endtask
  task automatic count_rises(input int n);
    logic pa, pb;
    n1 = 0;
    n2 = 0;
    repeat (n) begin
      pa = generated_line_clock_out;
      pb = reference_clock_output;
      @(posedge ref_clk);
      #2;
      if (generated_line_clock_out && !pa) n1++;
      if (reference_clock_output && !pb) n2++;
    end
  endtask
  always @(posedge ref_clk) begin
    cyc++;
    if (cyc == 3000) begin
      fail_count++;
      report_and_stop();
    end
  end
  ////////////////////////////////////////
  initial begin
    int t0;
    for (int s = 0; s < 8; s++) begin
      @(posedge ref_clk);
      #2;
      resetn = 1'b0;
      clock_select_strap = 3'(s);
      repeat (6) @(posedge ref_clk);
      #2;
      resetn = 1'b1;
      t0 = cyc;
      wr_reg(CRG_GP_CTRL_ADDR, 8'h05);
      rd_chk(CRG_GP_CTRL_ADDR, 8'h00);
      // Sample off the edge so the ready flag and the cycle count have both settled.
      while (reg_ready !== 1'b1 && cyc < t0 + 100) begin
        @(posedge ref_clk);
        #2;
      end
      chk("delay", 14'(DLY), 14'(cyc - t0));
      rd_chk(CRG_GP_CTRL_ADDR, 8'h04);
      chk("strap", {10'h0, s[2], 3'(s[1:0]) + 3'h1}, {10'h0, strap_cfg});
      chk("freq", 14'(s[1:0] + 1) * (s[2] ? 14'h0800 : 14'h0608), ref_freq_khz);
    end
    $display("test straps done");
    rd_chk(CRG_REF_CTRL_ADDR, 8'h00);
    wr_reg(CRG_GP_CTRL_ADDR, 8'h05);
    rd_chk(CRG_GP_CTRL_ADDR, 8'h05);
    chk("gp_drive", 14'h3, {12'h0, gp_pin_oe, gp_pin_out});
    ext_en = 1'b1;
    wr_reg(CRG_GP_CTRL_ADDR, 8'h00);
    rd_chk(CRG_GP_CTRL_ADDR, 8'h00);
    ext_en = 1'b0;
    wr_reg(8'h07, 8'hff);
    rd_chk(8'h07, 8'h00);
    rd_chk(CRG_GP_CTRL_ADDR, 8'h04);
    wr_reg(CRG_REF_CTRL_ADDR, 8'hff);
    rd_chk(CRG_REF_CTRL_ADDR, 8'h01);
    // A reset in mid-run must bring a written register back to its default.
    resetn = 1'b0;
    repeat (6) @(posedge ref_clk);
    #2;
    resetn = 1'b1;
    repeat (DLY + 1) @(posedge ref_clk);
    #2;
    rd_chk(CRG_REF_CTRL_ADDR, 8'h00);
    wr_reg(CRG_REF_CTRL_ADDR, 8'h01);
    $display("test registers done");
    signal_absent = 1'b1;
    @(posedge ref_clk);
    #2;
    count_rises(40);
    chk("ref_high", 14'h0, 14'(n2));
    chk("ref_lvl", 14'h1, {13'h0, reference_clock_output});
    wr_reg(CRG_REF_CTRL_ADDR, 8'h00);
    count_rises(520);
    chk("gen_rate", 14'h1, {13'h0, n1 inside {[26:27]}});
    chk("ref_mclk", 14'h1, {13'h0, n2 inside {[26:27]}});
    signal_absent = 1'b0;
    count_rises(60);
    chk("ref_line", 14'h1, {13'h0, n2 inside {[9:11]}});
    chk("osc_on", 14'h1, {13'h0, osc_active});
    osc_run = 1'b0;
    count_rises(20);
    count_rises(60);
    chk("gen_stop", 14'h0, 14'(n1));
    chk("osc_off", 14'h0, {13'h0, osc_active});
    chk("osc_out", {13'h0, !oscillator_input}, {13'h0, oscillator_output});
    osc_run = 1'b1;
    $display("test clocks done");
    tx_pos_data = 1'b1;
    repeat (2) @(posedge ref_clk);
    #2;
    chk("tx_on", 14'he, {10'h0, line_tx_positive_oe, line_tx_negative_oe,
      line_tx_positive_out, line_tx_negative_out});
    tx_high_impedance_in = 1'b1;
    tx_pos_data = 1'b0;
    tx_neg_data = 1'b1;
    repeat (2) @(posedge ref_clk);
    #2;
    chk("tx_hiz", 14'h1, {10'h0, line_tx_positive_oe, line_tx_negative_oe,
      line_tx_positive_out, line_tx_negative_out});
    $display("test transmit done");
    report_and_stop();
  end
endmodule // crg_clock_ctrl_test
`default_nettype wire
